// ### logic/dppc_pkg.sv
// Package for the downstream port power control block.
// Holds port numbering, reset values and input filter constants.
package dppc_pkg;
    localparam int        DPPC_NUM_PORTS   = 3;      // Ports 4, 5 and 6, index 0..2.
    localparam int        DPPC_FIRST_PORT  = 4;
    localparam int        DPPC_NO_SPLIT_IX = 2;      // Port 6 never splits.
    localparam int        DPPC_SYNC_STAGES = 3;
    localparam int        DPPC_OC_SETTLE   = DPPC_SYNC_STAGES + 1; // Cycles a released pin is distrusted.
    localparam logic      DPPC_RST_OE      = 1'b1;   // Pin driven low during reset.
    localparam logic      DPPC_RST_OC      = 1'b0;
    localparam logic      DPPC_PIN_IDLE    = 1'b1;   // Pulled-up level seen after reset.
endpackage

// ### logic/dppc_sync_if.sv
// Interface carrying one port's pin sample and its filtered level.
// Assumes one clock domain, shared by all users.
`timescale 1ns/1ns
`default_nettype none
interface dppc_sync_if;
    logic raw;
    logic level;
    logic chg;
    modport filt (input raw, output level, output chg);
    modport user (output raw, input level, input chg);
endinterface
`default_nettype wire

// ### logic/dppc_sync.sv
// Three-stage synchroniser with agreement filter for one pin input.
// Assumes the pin is asynchronous to REF_CLK.
`timescale 1ns/1ns
`default_nettype none
module dppc_sync
    import dppc_pkg::*;
(
    // Clock and reset.
    input  wire logic    clk,
    input  wire logic    rst,
    // Pin sample and filtered level.
    dppc_sync_if.filt    s
);
    typedef struct packed {
        logic [DPPC_SYNC_STAGES-1:0] sh;
        logic                        lvl;
        logic                        chg;
    } dppc_sync_st_t;

    dppc_sync_st_t st_q;
    dppc_sync_st_t st_d;

    // Shift the pin in; stages 1 and 2 must agree before the level moves.
    always_comb begin
        st_d     = st_q;
        st_d.sh  = {st_q.sh[DPPC_SYNC_STAGES-2:0], s.raw};
        st_d.chg = 1'b0;
        if (st_q.sh[1] == st_q.sh[2] && st_q.sh[2] != st_q.lvl) begin
            st_d.lvl = st_q.sh[2];
            st_d.chg = 1'b1;
        end
    end

    // Register the state.
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '{sh: {DPPC_SYNC_STAGES{DPPC_PIN_IDLE}}, lvl: DPPC_PIN_IDLE, chg: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign s.level = st_q.lvl;
    assign s.chg   = st_q.chg;
endmodule
`default_nettype wire

// ### logic/dppc_port_power.sv
// Power enable and overcurrent sense logic for downstream ports 4, 5 and 6.
// Assumes the pad supplies the pull-up while output enable is low.
// What this block does
// - Enabled port: pin is input with pull-up, which powers the port.
// - Enabled port: low on pin means overcurrent on that port.
// - Disabled port by config or host: pin drives low.
// - Port 6 pin always covers both USB 2.0 and 3.2 halves.
// - Ports 4, 5: split off covers both halves, split on only 2.0.
// - Disabling the USB 2.0 half also disables the USB 3.0 half.
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// Module ports
// ---------------------------------------------------------------
module dppc_port_power
    import dppc_pkg::*;
#(
    parameter int NPORT = DPPC_NUM_PORTS
)(
    // Clock and reset.
    input  wire logic             REF_CLK,
    input  wire logic             RESET,
    // Port disables from straps, configuration and host control, plus split mode, bit 0 is port 4.
    input  wire logic [NPORT-1:0] DPLUS_PORT_DISABLE_STRAP,
    input  wire logic [NPORT-1:0] DMINUS_PORT_DISABLE_STRAP,
    input  wire logic [NPORT-1:0] CFG_PORT_DISABLE,
    input  wire logic [NPORT-1:0] HOST_PORT_DISABLE,
    input  wire logic [NPORT-1:0] SPLIT_PORT_MODE,
    // Power and overcurrent pins, three signals each.
    input  wire logic [NPORT-1:0] PORT_POWER_OVERCURRENT_PIN_I,
    output logic      [NPORT-1:0] PORT_POWER_OVERCURRENT_PIN_O,
    output logic      [NPORT-1:0] PORT_POWER_OVERCURRENT_PIN_OE,
    // Per-port status to the hub core.
    output logic      [NPORT-1:0] USB2_HALF_ENABLE,
    output logic      [NPORT-1:0] USB3_HALF_ENABLE,
    output logic      [NPORT-1:0] USB2_OVERCURRENT,
    output logic      [NPORT-1:0] USB3_OVERCURRENT,
    output logic      [NPORT-1:0] OVERCURRENT_EVENT
);
    // ---------------------------------------------------------------
    // State and local signals
    // ---------------------------------------------------------------
    // One packed record holds every flip-flop of this module outside the pin synchronisers.
    typedef struct packed {
        logic [NPORT-1:0]      oe;     // Pin driven low, port power off.
        logic [NPORT-1:0]      oc;     // Qualified overcurrent level.
        logic [NPORT-1:0]      ev;     // One-cycle overcurrent start pulse.
        logic [NPORT-1:0]      split;  // Effective split mode per port.
        logic [NPORT-1:0][2:0] hold;   // Cycles left before the pin is trusted.
    } dppc_st_t;

    dppc_st_t         st_q;
    dppc_st_t         st_d;
    logic [NPORT-1:0] pin_lvl;
    logic [NPORT-1:0] pin_chg;
    logic [NPORT-1:0] disabled;
    logic [NPORT-1:0] split_eff;
    logic [NPORT-1:0] hold_busy;

    // ---------------------------------------------------------------
    // Per-port pin filters and port decode
    // ---------------------------------------------------------------
    // One synchroniser per pin, plus the per-port decode around it.
    for (genvar i = 0; i < NPORT; i++) begin : g_sync
        dppc_sync_if sif ();
        assign sif.raw    = PORT_POWER_OVERCURRENT_PIN_I[i];
        assign pin_lvl[i] = sif.level;
        assign pin_chg[i] = sif.chg;
        dppc_sync u_sync (
            .clk (REF_CLK),
            .rst (RESET),
            .s   (sif)
        );
        // A port is off when both strap halves, config or the host say so.
        assign disabled[i] = (DPLUS_PORT_DISABLE_STRAP[i] & DMINUS_PORT_DISABLE_STRAP[i])
                             | CFG_PORT_DISABLE[i] | HOST_PORT_DISABLE[i];
        // Port 6 ignores the split request.
        assign split_eff[i] = (i == DPPC_NO_SPLIT_IX) ? 1'b0 : SPLIT_PORT_MODE[i];
        // The pin is not trusted while its settle counter runs.
        assign hold_busy[i] = (st_q.hold[i] != 3'h0);
    end

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    // While the pin was driven low, the filter has learned a low level.
    // Once the drive is released, the pull-up needs the full synchroniser
    // depth plus the filter step before the filtered level is high again.
    // The settle counter hides that stale low, so re-enabling a port never
    // shows a false overcurrent. A monitor that really holds the pin low
    // is still reported as soon as the counter has run out.
    always_comb begin
        st_d       = st_q;
        st_d.oe    = disabled;
        st_d.split = split_eff;
        for (int j = 0; j < NPORT; j++) begin
            if (st_q.oe[j]) begin
                st_d.hold[j] = 3'(DPPC_OC_SETTLE);
            end else if (hold_busy[j]) begin
                st_d.hold[j] = st_q.hold[j] - 3'h1;
            end
        end
        st_d.oc    = ~pin_lvl & ~st_q.oe & ~disabled & ~hold_busy;
        // The event marks the cycle in which the qualified level rises.
        st_d.ev    = st_d.oc & ~st_q.oc;
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    // Register the state; reset drives every pin low.
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            st_q <= '{oe: {NPORT{DPPC_RST_OE}}, oc: {NPORT{DPPC_RST_OC}},
                      ev: '0, split: '0, hold: '0};
        end else begin
            st_q <= st_d;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    // Output drive is always low; the enable alone decides the pin.
    assign PORT_POWER_OVERCURRENT_PIN_O  = '0;
    assign PORT_POWER_OVERCURRENT_PIN_OE = st_q.oe;
    // The USB 3 half follows the USB 2 half when it is disabled.
    assign USB2_HALF_ENABLE  = ~st_q.oe;
    assign USB3_HALF_ENABLE  = ~st_q.oe;
    assign USB2_OVERCURRENT  = st_q.oc;
    assign USB3_OVERCURRENT  = st_q.oc & ~st_q.split;
    assign OVERCURRENT_EVENT = st_q.ev;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    // Every port powered, released and settled: the pin may be believed.
    sequence s_port_live;
        PORT_POWER_OVERCURRENT_PIN_OE == '0 && disabled == '0 && hold_busy == '0;
    endsequence

    // At least one port is asked to go off in this cycle.
    sequence s_port_off;
        disabled != '0;
    endsequence

    // A disabled port has its pin driven in the next cycle.
    a_pin_drive_low: assert property (@(posedge REF_CLK) disable iff (RESET)
        s_port_off |=> PORT_POWER_OVERCURRENT_PIN_OE == $past(disabled))
        else $error("Pin enable does not follow port disable.");

    // With every port enabled, every pin is released.
    a_pin_input_on: assert property (@(posedge REF_CLK) disable iff (RESET)
        (disabled == '0) |=> (PORT_POWER_OVERCURRENT_PIN_OE == '0))
        else $error("Enabled port pin is still driven.");

    // A driven pin never reports overcurrent.
    a_oc_masked: assert property (@(posedge REF_CLK) disable iff (RESET)
        (USB2_OVERCURRENT & PORT_POWER_OVERCURRENT_PIN_OE) == '0)
        else $error("Overcurrent reported on a driven pin.");

    // A settled enabled pin reports its filtered low level.
    a_oc_sense: assert property (@(posedge REF_CLK) disable iff (RESET)
        s_port_live |=> USB2_OVERCURRENT == ~$past(pin_lvl))
        else $error("Overcurrent does not follow a low pin.");

    // Port 6 always covers both halves.
    a_port6_both: assert property (@(posedge REF_CLK) disable iff (RESET)
        USB3_OVERCURRENT[DPPC_NO_SPLIT_IX] == USB2_OVERCURRENT[DPPC_NO_SPLIT_IX])
        else $error("Port 6 halves disagree on overcurrent.");

    // A split port keeps its overcurrent on the USB 2 half only.
    a_split_scope: assert property (@(posedge REF_CLK) disable iff (RESET)
        ##1 (USB3_OVERCURRENT & $past(split_eff)) == '0)
        else $error("Split port reports USB 3 overcurrent.");

    // An unsplit port shows the same overcurrent on both halves.
    a_usb3_unsplit: assert property (@(posedge REF_CLK) disable iff (RESET)
        ##1 ((USB3_OVERCURRENT ^ USB2_OVERCURRENT) & ~$past(split_eff)) == '0)
        else $error("Unsplit port halves disagree on overcurrent.");

    // The USB 3 half never reports what the USB 2 half does not.
    a_usb3_within: assert property (@(posedge REF_CLK) disable iff (RESET)
        (USB3_OVERCURRENT & ~USB2_OVERCURRENT) == '0)
        else $error("USB 3 overcurrent without USB 2 overcurrent.");

    // The USB 3 half is off whenever the USB 2 half is off.
    a_usb3_follows: assert property (@(posedge REF_CLK) disable iff (RESET)
        (~USB2_HALF_ENABLE & USB3_HALF_ENABLE) == '0)
        else $error("USB 3 half on while USB 2 half off.");

    // The USB 2 half is on exactly while its pin is released.
    a_usb2_enable: assert property (@(posedge REF_CLK) disable iff (RESET)
        USB2_HALF_ENABLE == ~PORT_POWER_OVERCURRENT_PIN_OE)
        else $error("USB 2 half enable disagrees with pin direction.");

    // The pad output value is low whenever it is driven.
    a_pin_out_low: assert property (@(posedge REF_CLK) disable iff (RESET)
        PORT_POWER_OVERCURRENT_PIN_O == '0)
        else $error("Pin driven to a high level.");

    // A port disabled in the last cycle reports no overcurrent.
    a_oc_after_off: assert property (@(posedge REF_CLK) disable iff (RESET)
        ##1 (USB2_OVERCURRENT & $past(disabled)) == '0)
        else $error("Overcurrent reported on a disabled port.");

    // A pin still settling after release reports no overcurrent.
    a_settle_mask: assert property (@(posedge REF_CLK) disable iff (RESET)
        ##1 (USB2_OVERCURRENT & $past(hold_busy)) == '0)
        else $error("Overcurrent reported while the pin settles.");

    // The event marks exactly the rise of the qualified level.
    a_event_rise: assert property (@(posedge REF_CLK) disable iff (RESET)
        ##1 OVERCURRENT_EVENT == (USB2_OVERCURRENT & ~$past(USB2_OVERCURRENT)))
        else $error("Overcurrent event not at the rise of overcurrent.");

    // The event never lasts more than one cycle.
    a_event_once: assert property (@(posedge REF_CLK) disable iff (RESET)
        (OVERCURRENT_EVENT != '0) |=> (OVERCURRENT_EVENT & $past(OVERCURRENT_EVENT)) == '0)
        else $error("Overcurrent event longer than one cycle.");

    // A filter change flag always comes with a new filtered level.
    a_level_change: assert property (@(posedge REF_CLK) disable iff (RESET)
        (pin_chg & ~(pin_lvl ^ $past(pin_lvl))) == '0)
        else $error("Filter change flag without a level change.");
endmodule
`default_nettype wire

// ### sim/dppc_switch_model.sv
// Model of the external power switch and current monitor on each pin.
// Assumes the pad pull-up wins whenever nobody pulls the pin low.
`timescale 1ns/1ns
`default_nettype none
module dppc_switch_model (
    // Pad drive from the block.
    input  wire logic [2:0] pin_o,
    input  wire logic [2:0] pin_oe,
    // Overcurrent request from the bench.
    input  wire logic [2:0] oc_req,
    // Resolved pin level.
    output logic      [2:0] pin
);
    // Monitor pulls low on overcurrent, otherwise the pull-up powers the port.
    assign pin = (pin_oe & pin_o) | (~pin_oe & ~oc_req);
endmodule
`default_nettype wire

// ### sim/dppc_port_power_test.sv
// Self-checking bench for the downstream port power control block.
// Assumes the switch model resolves each pin from drive and pull-up.
`timescale 1ns/1ns
`default_nettype none
module dppc_port_power_test;
    import dppc_pkg::*;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [2:0] dp = '0, dm = '0, cfg = '0, host = '0, spl = '0, oc = '0;
    wire  [2:0] pin_i, pin_o, pin_oe, en2, en3, oc2, oc3, ev;
    int         n_fail = 0, tests_run = 0, seed = 58995, i, k, hits;
    logic [31:0] r;
    // Free-running clock at 25 MHz.
    always #20 clk = ~clk;
    dppc_port_power dppc_port_power_inst (.REF_CLK(clk), .RESET(rst),
        .DPLUS_PORT_DISABLE_STRAP(dp), .DMINUS_PORT_DISABLE_STRAP(dm),
        .CFG_PORT_DISABLE(cfg), .HOST_PORT_DISABLE(host), .SPLIT_PORT_MODE(spl),
        .PORT_POWER_OVERCURRENT_PIN_I(pin_i), .PORT_POWER_OVERCURRENT_PIN_O(pin_o),
        .PORT_POWER_OVERCURRENT_PIN_OE(pin_oe), .USB2_HALF_ENABLE(en2),
        .USB3_HALF_ENABLE(en3), .USB2_OVERCURRENT(oc2), .USB3_OVERCURRENT(oc3),
        .OVERCURRENT_EVENT(ev));
    dppc_switch_model dppc_switch_model_inst (.pin_o(pin_o), .pin_oe(pin_oe),
        .oc_req(oc), .pin(pin_i));
    // A port is off when both strap halves, configuration or host say so.
    function automatic logic [2:0] dis_f();
        return (dp & dm) | cfg | host;
    endfunction
    // Compares one value and reports a mismatch.
    task automatic chk(input logic [2:0] got, input logic [2:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask
    // Waits n edges, then lets their updates land.
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("tests_run %0d n_fail %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Checks every output against the settled inputs.
    task automatic check_all();
        chk(pin_oe, dis_f(), "oe");
        chk(pin_o, 3'h0, "o");
        chk(en2, ~dis_f(), "en2");
        chk(en3, ~dis_f(), "en3");
        chk(oc2, ~dis_f() & oc, "oc2");
        chk(oc3, ~dis_f() & oc & ~(spl & 3'h3), "oc3");
        chk(ev, 3'h0, "ev idle");
    endtask
    // Main sequence: reset, overcurrent events, random settings, then re-enable.
    initial begin
        step(6);
        chk(pin_oe, 3'h7, "rst oe");
        chk(oc2 | ev, 3'h0, "rst oc");
        rst = 1'b0;
        step(10);
        check_all();
        $display("test reset done");
        spl = 3'h7;
        oc = 3'h7;
        hits = 0;
        for (k = 0; k < 12 && hits == 0; k++) begin
            step(1);
            if (ev !== 3'h0) hits = 1;
        end
        if (hits == 0) begin
            n_fail++;
            $display("[ERR] %0t no overcurrent event", $time);
        end
        chk(ev, 3'h7, "event");
        step(1);
        chk(ev, 3'h0, "event end");
        step(4);
        check_all();
        $display("test event done");
        for (i = 0; i < 60; i++) begin
            r = $random(seed);
            dp = r[2:0];
            dm = r[5:3];
            cfg = r[8:6] & r[11:9];
            host = r[14:12] & r[17:15];
            spl = r[20:18];
            oc = r[23:21] & r[26:24];
            step(10);
            check_all();
        end
        $display("test random done");
        dp = 3'h0;
        dm = 3'h0;
        host = 3'h0;
        spl = 3'h0;
        oc = 3'h0;
        cfg = 3'h7;
        step(10);
        check_all();
        cfg = 3'h0;
        for (k = 0; k < 8; k++) begin
            step(1);
            chk(oc2 | ev, 3'h0, "reenable");
        end
        check_all();
        $display("test reenable done");
        test_done();
    end
endmodule
`default_nettype wire
